// [logic/sbrg_pkg.sv]
// Package: register map, field positions and prescale constants for the baud generator
// How it works
// R01 - Bit-rate tick is divided down from the core clock only.
// R02 - Software rewrites the divisor after any clock frequency change.
// R03 - Receive line level is the majority of three samples.
// R04 - Async, 8-bit divisor, low speed: clock / (64 * (n + 1)).
// R05 - Async, 8-bit divisor, high speed: clock / (16 * (n + 1)).
// R06 - Async, 16-bit divisor, low speed: clock / (16 * (n + 1)).
// R07 - Sync, 8-bit divisor: clock / (4 * (n + 1)), high speed ignored.
// R08 - Divisor n is the high byte concatenated with the low byte.
// R09 - Baud control bits 5 and 2 always read as zero.
// R10 - Without wide divisor select the high divisor byte is ignored.
// R11 - Writing either divisor byte clears the rate counter at once.
// R12 - Rate counter runs continuously while the serial port is enabled.
// R13 - Async 16-bit high speed and sync 16-bit: clock / (4 * (n + 1)).
package sbrg_pkg;
   // -------------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------------
   localparam logic [4:0] ADDR_TX_CTRL   = 5'h00;
   localparam logic [4:0] ADDR_RX_CTRL   = 5'h04;
   localparam logic [4:0] ADDR_BAUD_CTRL = 5'h08;
   localparam logic [4:0] ADDR_DIV_HIGH  = 5'h0C;
   localparam logic [4:0] ADDR_DIV_LOW   = 5'h10;
   localparam logic [4:0] ADDR_STATUS    = 5'h14;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int TX_SYNC_BIT    = 4;
   localparam int TX_HSPEED_BIT  = 2;
   localparam int TX_EMPTY_BIT   = 1;
   localparam int RX_ENABLE_BIT  = 7;
   localparam int BD_IDLE_BIT    = 6;
   localparam int BD_WIDE_BIT    = 3;

   // Writable masks; read-only and unimplemented bits excluded
   localparam logic [7:0] TX_WR_MASK   = 8'hFD;
   localparam logic [7:0] RX_WR_MASK   = 8'hF8;
   localparam logic [7:0] BAUD_WR_MASK = 8'h9B;

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] TX_CTRL_RST   = 8'h00;
   localparam logic [7:0] RX_CTRL_RST   = 8'h00;
   localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
   localparam logic [7:0] DIV_RST       = 8'h00;

   // -------------------------------------------------------------------
   // Prescale terminal counts (divide minus one)
   // -------------------------------------------------------------------
   localparam logic [5:0] PRE_TERM_64 = 6'h3F;
   localparam logic [5:0] PRE_TERM_16 = 6'h0F;
   localparam logic [5:0] PRE_TERM_4  = 6'h03;

   localparam int GAP_W = 23;
endpackage : sbrg_pkg

// [logic/sbrg_majority.sv]
// Module: receive line synchroniser and three-sample majority detector
`timescale 1ns/1ps
module sbrg_majority
   import sbrg_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic rx_pin,
   input  wire logic sample_strobe,
   output logic      rx_level
);
   logic       sync1_reg;
   logic       sync2_reg;
   logic [2:0] samp_reg;

   // -------------------------------------------------------------------
   // Pin synchroniser
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= rx_pin;
         sync2_reg <= sync1_reg;
      end
   end

   // -------------------------------------------------------------------
   // Majority vote
   // -------------------------------------------------------------------
   // Idle line is high, so samples start high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_reg <= 3'h7;
         rx_level <= 1'b1;
      end else begin
         if (sample_strobe) begin
            samp_reg <= {samp_reg[1:0], sync2_reg};
         end
         rx_level <= (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & samp_reg[2])
                   | (samp_reg[1] & samp_reg[2]); // [R03]
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   two_high_a: assert property ( // [R03]
      ($countones(samp_reg) >= 2) |=> rx_level)
      else $error("majority of high samples did not give high level");
   two_low_a: assert property ( // [R03]
      ($countones(samp_reg) <= 1) |=> !rx_level)
      else $error("majority of low samples did not give low level");
endmodule : sbrg_majority

// [logic/sbrg_top.sv]
// Module: baud rate generator with register file on an Avalon-MM slave
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module sbrg_top
   import sbrg_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rx_pin,
   output logic             rate_tick,
   output logic             sample_tick,
   output logic             rx_level,
   output logic [7:0]       tx_ctrl,
   output logic [7:0]       rx_ctrl,
   output logic [7:0]       baud_ctrl
);
   logic        rst_meta_reg;
   logic        rst_n;
   logic        ack_reg;
   logic        wr_go;
   logic        div_write;
   logic [7:0]  div_high_reg;
   logic [7:0]  div_low_reg;
   logic [15:0] divisor;
   logic [5:0]  pre_term;
   logic [5:0]  pre_cnt_reg;
   logic [15:0] rate_cnt_reg;
   logic        pre_wrap;
   logic        port_en;
   logic        sync_mode;
   logic        hspeed;
   logic        wide;
   logic [7:0]  rd_byte;

   // -------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // -------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------
   // One wait cycle per access keeps read data registered
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign wr_go           = avs_write & ack_reg & avs_byteenable[0];
   assign div_write       = wr_go & ((avs_address == ADDR_DIV_HIGH)
                                   | (avs_address == ADDR_DIV_LOW));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
      end
   end

   // -------------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ctrl   <= TX_CTRL_RST;
         rx_ctrl   <= RX_CTRL_RST;
         baud_ctrl <= BAUD_CTRL_RST;
      end else if (wr_go) begin
         if (avs_address == ADDR_TX_CTRL) begin
            tx_ctrl <= avs_writedata[7:0] & TX_WR_MASK;
         end else if (avs_address == ADDR_RX_CTRL) begin
            rx_ctrl <= avs_writedata[7:0] & RX_WR_MASK;
         end else if (avs_address == ADDR_BAUD_CTRL) begin
            baud_ctrl <= avs_writedata[7:0] & BAUD_WR_MASK; // [R09]
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_high_reg <= DIV_RST;
         div_low_reg  <= DIV_RST;
      end else if (wr_go) begin
         if (avs_address == ADDR_DIV_HIGH) begin
            div_high_reg <= avs_writedata[7:0];
         end else if (avs_address == ADDR_DIV_LOW) begin
            div_low_reg <= avs_writedata[7:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------
   // No transmitter here, so the shift register always shows empty
   always_comb begin
      rd_byte = 8'h00;
      if (avs_address == ADDR_TX_CTRL) begin
         rd_byte = tx_ctrl | (8'h01 << TX_EMPTY_BIT);
      end else if (avs_address == ADDR_RX_CTRL) begin
         rd_byte = rx_ctrl;
      end else if (avs_address == ADDR_BAUD_CTRL) begin
         rd_byte = (baud_ctrl & BAUD_WR_MASK) | (8'h01 << BD_IDLE_BIT); // [R09]
      end else if (avs_address == ADDR_DIV_HIGH) begin
         rd_byte = div_high_reg;
      end else if (avs_address == ADDR_DIV_LOW) begin
         rd_byte = div_low_reg;
      end else if (avs_address == ADDR_STATUS) begin
         rd_byte = {6'h00, rate_tick, rx_level};
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack_reg) begin
         avs_readdata <= {24'h00_0000, rd_byte};
      end
   end

   // -------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------
   assign port_en   = rx_ctrl[RX_ENABLE_BIT];
   assign sync_mode = tx_ctrl[TX_SYNC_BIT];
   assign hspeed    = tx_ctrl[TX_HSPEED_BIT];
   assign wide      = baud_ctrl[BD_WIDE_BIT];
   assign divisor   = wide ? {div_high_reg, div_low_reg} // [R08]
                           : {8'h00, div_low_reg};       // [R10]

   always_comb begin
      if (sync_mode) begin
         pre_term = PRE_TERM_4; // [R07] [R13]
      end else if (wide & hspeed) begin
         pre_term = PRE_TERM_4; // [R13]
      end else if (wide | hspeed) begin
         pre_term = PRE_TERM_16; // [R05] [R06]
      end else begin
         pre_term = PRE_TERM_64; // [R04]
      end
   end

   // -------------------------------------------------------------------
   // Prescaler and rate counter
   // -------------------------------------------------------------------
   // Counts on the core clock alone; a clock change scales the rate
   assign pre_wrap = pre_cnt_reg >= pre_term; // [R01]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_reg  <= 6'h00;
         rate_cnt_reg <= 16'h0000;
      end else if (!port_en || div_write) begin
         pre_cnt_reg  <= 6'h00; // [R11] [R12]
         rate_cnt_reg <= 16'h0000;
      end else if (pre_wrap) begin
         pre_cnt_reg <= 6'h00;
         if (rate_cnt_reg >= divisor) begin
            rate_cnt_reg <= 16'h0000;
         end else begin
            rate_cnt_reg <= rate_cnt_reg + 16'h0001; // [R12]
         end
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 6'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rate_tick   <= 1'b0;
         sample_tick <= 1'b0;
      end else begin
         rate_tick   <= port_en & ~div_write & pre_wrap & (rate_cnt_reg >= divisor);
         sample_tick <= port_en & ~div_write & pre_wrap;
      end
   end

   // -------------------------------------------------------------------
   // Receive sampling
   // -------------------------------------------------------------------
   sbrg_majority u_majority (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .rx_pin        (rx_pin),
      .sample_strobe (sample_tick),
      .rx_level      (rx_level)
   );

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   logic [GAP_W-1:0] gap_reg;
   logic             gap_ok_reg;
   logic [GAP_W-1:0] n_plus1;

   assign n_plus1 = {7'h00, divisor} + 23'h000001;

   // Gap is trusted only between two ticks with no write in between
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg    <= '0;
         gap_ok_reg <= 1'b0;
      end else begin
         gap_reg    <= rate_tick ? '0 : gap_reg + 23'h000001;
         if (wr_go || !port_en) begin
            gap_ok_reg <= 1'b0;
         end else if (rate_tick) begin
            gap_ok_reg <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Prescale checks
   // -------------------------------------------------------------------
   logic [5:0] samp_gap_reg;
   logic       samp_ok_reg;

   // Same idea as the rate gap, one level down at the sample strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_gap_reg <= 6'h00;
         samp_ok_reg  <= 1'b0;
      end else begin
         samp_gap_reg <= sample_tick ? 6'h00 : samp_gap_reg + 6'h01;
         if (wr_go || !port_en) begin
            samp_ok_reg <= 1'b0;
         end else if (sample_tick) begin
            samp_ok_reg <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   div_clear_a: assert property ( // [R11]
      div_write |=> (pre_cnt_reg == 6'h00) && (rate_cnt_reg == 16'h0000) && !rate_tick)
      else $error("divisor write did not clear the rate counter");
   held_off_a: assert property ( // [R12]
      !port_en |=> !rate_tick && (rate_cnt_reg == 16'h0000))
      else $error("rate counter ran while the port was disabled");
   narrow_div_a: assert property ( // [R10]
      !wide |-> (divisor[15:8] == 8'h00) && (divisor[7:0] == div_low_reg))
      else $error("high divisor byte leaked into the narrow divisor");
   wide_div_a: assert property ( // [R08]
      wide |-> divisor == {div_high_reg, div_low_reg})
      else $error("wide divisor is not the byte pair");
   async_low8_a: assert property ( // [R04]
      rate_tick && gap_ok_reg && !sync_mode && !wide && !hspeed
      |-> gap_reg == (n_plus1 << 6) - 23'h000001)
      else $error("tick period is not 64 times divisor plus one");
   async_high8_a: assert property ( // [R05]
      rate_tick && gap_ok_reg && !sync_mode && !wide && hspeed
      |-> gap_reg == (n_plus1 << 4) - 23'h000001)
      else $error("tick period is not 16 times divisor plus one");
   async_low16_a: assert property ( // [R06]
      rate_tick && gap_ok_reg && !sync_mode && wide && !hspeed
      |-> gap_reg == (n_plus1 << 4) - 23'h000001)
      else $error("wide tick period is not 16 times divisor plus one");
   sync_narrow_a: assert property ( // [R07]
      rate_tick && gap_ok_reg && sync_mode && !wide
      |-> gap_reg == (n_plus1 << 2) - 23'h000001)
      else $error("sync tick period is not 4 times divisor plus one");
   quad_wide_a: assert property ( // [R13]
      rate_tick && gap_ok_reg && wide && (sync_mode || hspeed)
      |-> gap_reg == (n_plus1 << 2) - 23'h000001)
      else $error("fast wide tick period is not 4 times divisor plus one");
   clock_ratio_a: assert property ( // [R01]
      sample_tick |-> $past(pre_wrap) && $past(port_en))
      else $error("sample tick not from the core clock prescaler");
   unimpl_zero_a: assert property ( // [R09]
      avs_read && !avs_waitrequest && (avs_address == ADDR_BAUD_CTRL)
      |-> (avs_readdata[5] == 1'b0) && (avs_readdata[2] == 1'b0))
      else $error("unimplemented baud control bits read as one");
   samp_period_a: assert property ( // [R01]
      sample_tick && samp_ok_reg |-> samp_gap_reg == pre_term)
      else $error("sample strobe period is not the prescale");
   idle_samp_a: assert property ( // [R12]
      !port_en |=> !sample_tick)
      else $error("sample strobe ran while the port was disabled");
   rd_upper_a: assert property ( // [R09]
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
      else $error("upper read data bits are not zero");
   div_low_wr_a: assert property ( // [R08]
      wr_go && (avs_address == ADDR_DIV_LOW) |=> div_low_reg == $past(avs_writedata[7:0]))
      else $error("low divisor byte did not take the write");
   div_high_wr_a: assert property ( // [R08]
      wr_go && (avs_address == ADDR_DIV_HIGH) |=> div_high_reg == $past(avs_writedata[7:0]))
      else $error("high divisor byte did not take the write");

   tick_low_cov: cover property (rate_tick && gap_ok_reg && !wide && !hspeed && !sync_mode);
   tick_wide_cov: cover property (rate_tick && gap_ok_reg && wide && hspeed);
   div_mid_cov: cover property (div_write && (rate_cnt_reg != 16'h0000));
   rx_low_cov: cover property (!rx_level);
   sync_wide_cov: cover property (rate_tick && gap_ok_reg && wide && sync_mode);
endmodule : sbrg_top

// [bench/sbrg_line_model.sv]
// Model: remote serial transmitter driving the receive line
`timescale 1ns/1ps
module sbrg_line_model (
   input  wire logic core_clk,
   input  wire logic line_level,
   input  wire logic glitch,
   output logic      rx_pin
);
   // -------------------------------------------------------------------
   // Line driver
   // -------------------------------------------------------------------
   // Idle line is high; a glitch inverts the level for a single cycle
   // Unknown until the first edge, well inside reset
   always @(posedge core_clk) begin
      rx_pin <= glitch ? ~line_level : line_level;
   end
endmodule : sbrg_line_model

// [bench/test_serial_baud_rate_generator.sv]
// Testbench: register access, rate periods and receive vote of the baud generator
`timescale 1ns/1ps
module test_serial_baud_rate_generator
   import sbrg_pkg::*;
;
   logic        core_clk;
   logic        rstn;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        rx_pin;
   logic        rate_tick;
   logic        sample_tick;
   logic        rx_level;
   logic        line_level;
   logic        glitch;
   logic        wait_s;
   logic        rate_s;
   logic        samp_s;
   logic        lvl_s;
   logic [31:0] data_s;
   logic [7:0]  tx_c;
   logic [7:0]  rx_c;
   logic [7:0]  bd_c;
   int          err_total;
   int          n_checks;

   // -------------------------------------------------------------------
   // Design and line partner
   // -------------------------------------------------------------------
   sbrg_top i_dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .rate_tick(rate_tick),
      .sample_tick(sample_tick), .rx_level(rx_level), .tx_ctrl(tx_c), .rx_ctrl(rx_c),
      .baud_ctrl(bd_c));
   sbrg_line_model i_line (.core_clk(core_clk), .line_level(line_level),
      .glitch(glitch), .rx_pin(rx_pin));

   // Sampled mid-cycle so edge-time updates never race the checks
   always @(negedge core_clk) begin
      wait_s <= avs_waitrequest;
      rate_s <= rate_tick;
      samp_s <= sample_tick;
      lvl_s  <= rx_level;
      data_s <= avs_readdata;
   end

   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int k;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_write     <= w;
      avs_read      <= ~w;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (wait_s !== 1'b0 && k < 50);
      q = data_s;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (k >= 50) begin
         chk(32'h0, 32'h1);
         wrap_up();
      end
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask : rd

   // Counts edges until the chosen tick is seen; -1 when it never comes
   task automatic gap(input logic smp, input int lim, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((smp ? samp_s : rate_s) !== 1'b1 && n < lim);
      if ((smp ? samp_s : rate_s) !== 1'b1) n = -1;
   endtask : gap

   task automatic run_mode(input logic [7:0] tx, input logic [7:0] bd, input logic [7:0] hi,
                           input logic [7:0] lo, input int pre);
      int p;
      int n;
      p = pre * (int'(bd[BD_WIDE_BIT] ? {hi, lo} : {8'h00, lo}) + 1);
      wr(ADDR_TX_CTRL, tx);
      wr(ADDR_BAUD_CTRL, bd);
      wr(ADDR_DIV_HIGH, hi);
      wr(ADDR_DIV_LOW, lo);
      // A tick already launched at the write edge is skipped
      do gap(1'b0, p + 10, n); while (n == 1);
      chk(32'(n >= p && n <= p + 2), 32'h1);
      gap(1'b0, p + 10, n);
      chk(32'(n), 32'(p));
      chk(32'({tx_c, rx_c, bd_c}), 32'({tx & TX_WR_MASK, 8'h80, bd & BAUD_WR_MASK}));
      gap(1'b1, 100, n);
      gap(1'b1, 100, n);
      chk(32'(n), 32'(pre));
   endtask : run_mode

   // -------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // -------------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial begin
      repeat (30000) @(posedge core_clk);
      err_total++;
      wrap_up();
   end

   initial begin
      int          n;
      logic [31:0] q;
      logic        hold;
      rstn           = 1'b0;
      avs_address    = 5'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h00000000;
      avs_byteenable = 4'h1;
      line_level     = 1'b1;
      glitch         = 1'b0;
      err_total      = 0;
      n_checks       = 0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(32'(lvl_s), 32'h1);
      rd(ADDR_TX_CTRL, 32'h00000002);
      rd(ADDR_BAUD_CTRL, 32'h00000040);
      rd(ADDR_DIV_HIGH, 32'h00000000);
      rd(ADDR_DIV_LOW, 32'h00000000);
      wr(ADDR_BAUD_CTRL, 8'hFF);
      rd(ADDR_BAUD_CTRL, 32'h000000DB);
      chk(32'(bd_c), 32'(BAUD_WR_MASK));
      wr(5'h18, 8'hFF);
      rd(5'h18, 32'h00000000);
      avs_byteenable <= 4'h0;
      wr(ADDR_BAUD_CTRL, 8'h00);
      avs_byteenable <= 4'h1;
      rd(ADDR_BAUD_CTRL, 32'h000000DB);
      gap(1'b0, 400, n);
      chk(32'(n), 32'hFFFFFFFF);
      wr(ADDR_RX_CTRL, 8'h80);
      run_mode(8'h00, 8'h00, 8'h05, 8'h02, 64);
      run_mode(8'h04, 8'h00, 8'h00, 8'h02, 16);
      run_mode(8'h00, 8'h08, 8'h00, 8'h03, 16);
      run_mode(8'h00, 8'h08, 8'h01, 8'h00, 16);
      run_mode(8'h10, 8'h00, 8'h00, 8'h02, 4);
      run_mode(8'h14, 8'h00, 8'h00, 8'h02, 4);
      run_mode(8'h04, 8'h08, 8'h00, 8'h05, 4);
      run_mode(8'h10, 8'h08, 8'h01, 8'h02, 4);
      run_mode(8'h10, 8'h00, 8'h00, 8'h00, 4);
      line_level <= 1'b0;
      repeat (40) @(posedge core_clk);
      chk(32'(lvl_s), 32'h0);
      // One noisy cycle can land on one sample only, so the vote holds
      glitch <= 1'b1;
      @(posedge core_clk);
      glitch <= 1'b0;
      hold = 1'b1;
      repeat (40) begin
         @(posedge core_clk);
         if (lvl_s !== 1'b0) hold = 1'b0;
      end
      chk(32'(hold), 32'h1);
      line_level <= 1'b1;
      repeat (40) @(posedge core_clk);
      chk(32'(lvl_s), 32'h1);
      bus(1'b0, ADDR_STATUS, 8'h00, q);
      chk(q & 32'h00000001, 32'h00000001);
      wr(ADDR_RX_CTRL, 8'h00);
      // A tick launched at the disabling write edge is still legal
      repeat (2) @(posedge core_clk);
      gap(1'b0, 400, n);
      chk(32'(n), 32'hFFFFFFFF);
      chk(32'(rx_c), 32'h00000000);
      wrap_up();
   end
endmodule : test_serial_baud_rate_generator
